//--- verilog/fgic_consts.svh
`ifndef FGIC_CONSTS_SVH
`define FGIC_CONSTS_SVH

// =====================================================================
// Clock and timing
`define FGIC_CLK_MHZ 200
`define FGIC_WAIT_TIME_US 2000
`define FGIC_WAIT_CYCLES (`FGIC_WAIT_TIME_US * `FGIC_CLK_MHZ)

// =====================================================================
// Regulator counts
`define FGIC_NUM_BUCK 7
`define FGIC_NUM_LINREG 4
`define FGIC_NUM_REG 11

// =====================================================================
// Latch groups
`define FGIC_NUM_GRP 10
`define FGIC_GRP_STATUS1 0
`define FGIC_GRP_THERMAL 1
`define FGIC_GRP_BUCK_MODE 2
`define FGIC_GRP_BUCK_CURRENT_LIMIT_FAULT 3
`define FGIC_GRP_LIN_CURRENT_LIMIT_FAULT 4
`define FGIC_GRP_BUCK_LOWV 5
`define FGIC_GRP_BUCK_HIGHV 6
`define FGIC_GRP_LIN_LOWV 7
`define FGIC_GRP_LIN_HIGHV 8
`define FGIC_GRP_BUTTON 9

// =====================================================================
// Register indices: latch, mask, sense per group, then summary
`define FGIC_IDX_STRIDE 3
`define FGIC_IDX_LATCH 0
`define FGIC_IDX_MASK 1
`define FGIC_IDX_SENSE 2
`define FGIC_IDX_SUMMARY 5'h1e

// =====================================================================
// Reset values and implemented bits
`define FGIC_LATCH_RST 8'h00
`define FGIC_MASK_RST 8'hff
`define FGIC_VALID_FULL 8'hff
`define FGIC_VALID_BUCK 8'h7f
`define FGIC_VALID_LINREG 8'h0f
`define FGIC_SENSE_STATUS1 8'h07
`define FGIC_SENSE_BUTTON 8'h81

// =====================================================================
// Summary bit positions
`define FGIC_SUM_GROUP1 0
`define FGIC_SUM_GROUP2 1
`define FGIC_SUM_MODE 2
`define FGIC_SUM_CURRENT_LIMIT_FAULT 3
`define FGIC_SUM_LOWV 4
`define FGIC_SUM_HIGHV 5
`define FGIC_SUM_BUTTON 6
`define FGIC_SUM_EWARN 7

`endif

//--- verilog/fgic_pkg.sv
package fgic_pkg;

    typedef enum logic [3:0] {
        FGIC_ST_IDLE = 4'b0001,
        FGIC_ST_WAIT = 4'b0010,
        FGIC_ST_RELEASED = 4'b0100,
        FGIC_ST_ABORT = 4'b1000
    } fgic_state_t;

    typedef struct packed {
        logic [10:0] high_voltage;
        logic [10:0] low_voltage;
        logic [10:0] current_limit;
    } fgic_fault_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [4:0] idx;
        logic [7:0] wdata;
    } fgic_reg_req_t;

    typedef struct packed {
        logic hit;
        logic summary;
        logic [3:0] grp;
        logic [1:0] kind;
    } fgic_decode_t;

endpackage

//--- verilog/fgic_latch_bank.sv
`timescale 1ns/1ps
`include "fgic_consts.svh"

module fgic_latch_bank
#(
    parameter logic [7:0] VALID_BITS = 8'hff
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [7:0] set_evt,
    input wire logic clear_wr,
    input wire logic mask_wr,
    input wire logic [7:0] wdata,
    output logic [7:0] latch_reg,
    output logic [7:0] mask_reg,
    output logic pending
);

    logic [7:0] latch_next;

    // =================================================================
    // Event latches, write one to clear, set wins
    always_comb
    begin
        latch_next = latch_reg;
        if (clear_wr)
        begin
            latch_next = latch_reg & ~wdata;
        end
        latch_next = (latch_next | set_evt) & VALID_BITS;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            latch_reg <= `FGIC_LATCH_RST;
        end
        else
        begin
            latch_reg <= latch_next;
        end
    end

    // =================================================================
    // Mask
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mask_reg <= `FGIC_MASK_RST & VALID_BITS;
        end
        else if (mask_wr)
        begin
            mask_reg <= wdata & VALID_BITS;
        end
    end

    assign pending = |(latch_reg & ~mask_reg);

endmodule

//--- verilog/fgic_wait_timer.sv
`timescale 1ns/1ps

module fgic_wait_timer
#(
    parameter int unsigned CYCLES = 400000
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic run,
    output logic expired
);

    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count_reg;

    // =================================================================
    // Counts while run is high, restarts when it drops
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count_reg <= '0;
        end
        else if (!run)
        begin
            count_reg <= '0;
        end
        else if (count_reg != LAST)
        begin
            count_reg <= count_reg + CW'(1);
        end
    end

    assign expired = run && (count_reg == LAST);

endmodule

//--- verilog/fgic_core.sv
`timescale 1ns/1ps
`include "fgic_consts.svh"

module fgic_core
    import fgic_pkg::*;
#(
    parameter int unsigned WAIT_CYCLES = `FGIC_WAIT_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire fgic_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic powerup_check_select,
    input wire logic power_good_pin_mode_sel,
    input wire logic reset_point_reached,
    input wire logic power_down_req,
    input wire logic [10:0] regulator_enabled,
    input wire logic [10:0] regulation_ok,
    input wire logic [10:0] blanking_done,
    input wire fgic_fault_t fault,
    input wire fgic_fault_t fault_bypass,
    input wire logic [7:0] status1_event,
    input wire logic [2:0] status1_live,
    input wire logic [7:0] thermal_event,
    input wire logic [7:0] thermal_live,
    input wire logic [6:0] buck_mode_event,
    input wire logic [7:0] button_event,
    input wire logic [1:0] button_live,
    input wire logic early_warning,
    output logic host_reset_out_n,
    output logic sequence_hold,
    output logic sequence_abort,
    output logic [10:0] regulator_off_req,
    output logic [10:0] voltage_monitor_en,
    output fgic_fault_t protection_start,
    output logic power_good_pin,
    output logic interrupt_out_n_o,
    output logic interrupt_out_n_oe_n
);

    // =================================================================
    // Decoding helpers
    function automatic fgic_decode_t decode_idx(input logic [4:0] idx);
        fgic_decode_t d;
        d = '0;
        if (idx == `FGIC_IDX_SUMMARY)
        begin
            d.hit = 1'b1;
            d.summary = 1'b1;
        end
        for (int g = 0; g < `FGIC_NUM_GRP; g++)
        begin
            for (int k = 0; k < `FGIC_IDX_STRIDE; k++)
            begin
                if (idx == 5'(g * `FGIC_IDX_STRIDE + k))
                begin
                    d.hit = 1'b1;
                    d.grp = 4'(g);
                    d.kind = 2'(k);
                end
            end
        end
        return d;
    endfunction

    function automatic logic [7:0] group_valid(input int g);
        logic [7:0] v;
        v = `FGIC_VALID_FULL;
        if (g == `FGIC_GRP_BUCK_MODE || g == `FGIC_GRP_BUCK_CURRENT_LIMIT_FAULT ||
            g == `FGIC_GRP_BUCK_LOWV || g == `FGIC_GRP_BUCK_HIGHV)
        begin
            v = `FGIC_VALID_BUCK;
        end
        if (g == `FGIC_GRP_LIN_CURRENT_LIMIT_FAULT || g == `FGIC_GRP_LIN_LOWV ||
            g == `FGIC_GRP_LIN_HIGHV)
        begin
            v = `FGIC_VALID_LINREG;
        end
        return v;
    endfunction

    function automatic logic [7:0] buck_part(input logic [10:0] v);
        return {1'b0, v[`FGIC_NUM_BUCK-1:0]};
    endfunction

    function automatic logic [7:0] linreg_part(input logic [10:0] v);
        return {4'h0, v[`FGIC_NUM_REG-1:`FGIC_NUM_BUCK]};
    endfunction

    // =================================================================
    // Power-up supervision state machine
    fgic_state_t state_reg;
    fgic_state_t state_next;
    logic all_enabled_ok;
    logic wait_run;
    logic wait_expired;
    logic released;
    logic pu_check_fail_reg;
    logic [10:0] pu_report;

    assign all_enabled_ok = &(regulation_ok | ~regulator_enabled);
    assign wait_run = (state_reg == FGIC_ST_WAIT);
    assign released = (state_reg == FGIC_ST_RELEASED);

    fgic_wait_timer #(
        .CYCLES(WAIT_CYCLES)
    ) u_wait_timer (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .run(wait_run),
        .expired(wait_expired)
    );

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            FGIC_ST_IDLE:
            begin
                if (reset_point_reached)
                begin
                    if (!powerup_check_select || all_enabled_ok)
                    begin
                        state_next = FGIC_ST_RELEASED;
                    end
                    else
                    begin
                        state_next = FGIC_ST_WAIT;
                    end
                end
            end
            FGIC_ST_WAIT:
            begin
                if (all_enabled_ok)
                begin
                    state_next = FGIC_ST_RELEASED;
                end
                else if (wait_expired)
                begin
                    state_next = FGIC_ST_ABORT;
                end
            end
            FGIC_ST_RELEASED:
            begin
                // Later faults never send the sequence back
                if (power_down_req)
                begin
                    state_next = FGIC_ST_IDLE;
                end
            end
            FGIC_ST_ABORT:
            begin
                if (power_down_req)
                begin
                    state_next = FGIC_ST_IDLE;
                end
            end
            default:
            begin
                state_next = FGIC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= FGIC_ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign host_reset_out_n = released;
    assign sequence_hold = (state_reg == FGIC_ST_WAIT) || (state_reg == FGIC_ST_ABORT);
    assign sequence_abort = (state_reg == FGIC_ST_ABORT);

    // Snapshot of what to switch off on abort
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            regulator_off_req <= '0;
        end
        else if (state_reg == FGIC_ST_WAIT && state_next == FGIC_ST_ABORT)
        begin
            regulator_off_req <= regulator_enabled;
        end
        else if (state_reg != FGIC_ST_ABORT)
        begin
            regulator_off_req <= '0;
        end
    end

    // Release-point failure seen with checking on
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pu_check_fail_reg <= 1'b0;
        end
        else if (state_reg == FGIC_ST_IDLE && state_next == FGIC_ST_WAIT)
        begin
            pu_check_fail_reg <= 1'b1;
        end
        else if (state_next == FGIC_ST_RELEASED || state_next == FGIC_ST_IDLE)
        begin
            pu_check_fail_reg <= 1'b0;
        end
    end

    assign power_good_pin = !(power_good_pin_mode_sel && pu_check_fail_reg);

    // Power-up faults reported from regulation ok at the release check
    assign pu_report = (state_reg == FGIC_ST_IDLE && state_next == FGIC_ST_WAIT) ?
        (regulator_enabled & ~regulation_ok) : '0;

    // =================================================================
    // Fault qualification after release
    fgic_fault_t checked;
    fgic_fault_t checked_prev_reg;
    fgic_fault_t fault_evt;

    assign voltage_monitor_en = released ? blanking_done : '0;

    always_comb
    begin
        checked.high_voltage = fault.high_voltage & voltage_monitor_en &
            regulator_enabled;
        checked.low_voltage = fault.low_voltage & voltage_monitor_en & regulator_enabled;
        checked.current_limit = fault.current_limit & regulator_enabled &
            {11{released}};
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            checked_prev_reg <= '0;
        end
        else
        begin
            checked_prev_reg <= checked;
        end
    end

    // Bypass blocks protection only, latches still set
    always_comb
    begin
        fault_evt = checked & ~checked_prev_reg;
        fault_evt.high_voltage = fault_evt.high_voltage |
            (pu_report & fault.high_voltage);
        fault_evt.low_voltage = fault_evt.low_voltage |
            (pu_report & ~fault.high_voltage);
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            protection_start <= '0;
        end
        else
        begin
            protection_start <= checked & ~fault_bypass;
        end
    end

    // =================================================================
    // Second-level latch groups
    logic [7:0] set_arr [`FGIC_NUM_GRP];
    logic [7:0] sense_arr [`FGIC_NUM_GRP];
    logic [7:0] latch_arr [`FGIC_NUM_GRP];
    logic [7:0] mask_arr [`FGIC_NUM_GRP];
    logic [`FGIC_NUM_GRP-1:0] pend;
    fgic_decode_t wr_dec;
    fgic_decode_t rd_dec;

    assign wr_dec = decode_idx(reg_req.idx);
    assign rd_dec = wr_dec;

    always_comb
    begin
        set_arr[`FGIC_GRP_STATUS1] = status1_event;
        set_arr[`FGIC_GRP_THERMAL] = thermal_event;
        set_arr[`FGIC_GRP_BUCK_MODE] = {1'b0, buck_mode_event};
        set_arr[`FGIC_GRP_BUCK_CURRENT_LIMIT_FAULT] = buck_part(fault_evt.current_limit);
        set_arr[`FGIC_GRP_LIN_CURRENT_LIMIT_FAULT] = linreg_part(fault_evt.current_limit);
        set_arr[`FGIC_GRP_BUCK_LOWV] = buck_part(fault_evt.low_voltage);
        set_arr[`FGIC_GRP_BUCK_HIGHV] = buck_part(fault_evt.high_voltage);
        set_arr[`FGIC_GRP_LIN_LOWV] = linreg_part(fault_evt.low_voltage);
        set_arr[`FGIC_GRP_LIN_HIGHV] = linreg_part(fault_evt.high_voltage);
        set_arr[`FGIC_GRP_BUTTON] = button_event;
    end

    always_comb
    begin
        sense_arr[`FGIC_GRP_STATUS1] = {5'h00, status1_live} & `FGIC_SENSE_STATUS1;
        sense_arr[`FGIC_GRP_THERMAL] = thermal_live;
        sense_arr[`FGIC_GRP_BUCK_MODE] = 8'h00;
        sense_arr[`FGIC_GRP_BUCK_CURRENT_LIMIT_FAULT] = buck_part(fault.current_limit);
        sense_arr[`FGIC_GRP_LIN_CURRENT_LIMIT_FAULT] = linreg_part(fault.current_limit);
        sense_arr[`FGIC_GRP_BUCK_LOWV] = buck_part(fault.low_voltage);
        sense_arr[`FGIC_GRP_BUCK_HIGHV] = buck_part(fault.high_voltage);
        sense_arr[`FGIC_GRP_LIN_LOWV] = linreg_part(fault.low_voltage);
        sense_arr[`FGIC_GRP_LIN_HIGHV] = linreg_part(fault.high_voltage);
        sense_arr[`FGIC_GRP_BUTTON] = {button_live[1], 6'h00, button_live[0]} &
            `FGIC_SENSE_BUTTON;
    end

    genvar gi;
    generate
        for (gi = 0; gi < `FGIC_NUM_GRP; gi++)
        begin : g_bank
            logic clr_wr;
            logic msk_wr;
            // Sense and summary writes reach no storage
            assign clr_wr = reg_req.wr && wr_dec.hit && !wr_dec.summary &&
                wr_dec.grp == 4'(gi) && wr_dec.kind == 2'(`FGIC_IDX_LATCH);
            assign msk_wr = reg_req.wr && wr_dec.hit && !wr_dec.summary &&
                wr_dec.grp == 4'(gi) && wr_dec.kind == 2'(`FGIC_IDX_MASK);
            fgic_latch_bank #(
                .VALID_BITS(group_valid(gi))
            ) u_bank (
                .sys_clk(sys_clk),
                .rst_b(rst_b),
                .set_evt(set_arr[gi]),
                .clear_wr(clr_wr),
                .mask_wr(msk_wr),
                .wdata(reg_req.wdata),
                .latch_reg(latch_arr[gi]),
                .mask_reg(mask_arr[gi]),
                .pending(pend[gi])
            );
        end
    endgenerate

    // =================================================================
    // First-level summary and interrupt pin
    logic [7:0] summary;

    always_comb
    begin
        summary = 8'h00;
        summary[`FGIC_SUM_GROUP1] = pend[`FGIC_GRP_STATUS1];
        summary[`FGIC_SUM_GROUP2] = pend[`FGIC_GRP_THERMAL];
        summary[`FGIC_SUM_MODE] = pend[`FGIC_GRP_BUCK_MODE];
        summary[`FGIC_SUM_CURRENT_LIMIT_FAULT] = pend[`FGIC_GRP_BUCK_CURRENT_LIMIT_FAULT] |
            pend[`FGIC_GRP_LIN_CURRENT_LIMIT_FAULT];
        summary[`FGIC_SUM_LOWV] = pend[`FGIC_GRP_BUCK_LOWV] | pend[`FGIC_GRP_LIN_LOWV];
        summary[`FGIC_SUM_HIGHV] = pend[`FGIC_GRP_BUCK_HIGHV] | pend[`FGIC_GRP_LIN_HIGHV];
        summary[`FGIC_SUM_BUTTON] = pend[`FGIC_GRP_BUTTON];
        summary[`FGIC_SUM_EWARN] = early_warning;
    end

    // Summary is derived: bits 0-6 clear with their latches, bit 7 follows early_warning
    assign interrupt_out_n_o = 1'b0;
    assign interrupt_out_n_oe_n = ~(|summary);

    // =================================================================
    // Register read port
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd)
            begin
                if (!rd_dec.hit)
                begin
                    reg_rdata <= 8'h00;
                end
                else if (rd_dec.summary)
                begin
                    reg_rdata <= summary;
                end
                else if (rd_dec.kind == 2'(`FGIC_IDX_LATCH))
                begin
                    reg_rdata <= latch_arr[rd_dec.grp];
                end
                else if (rd_dec.kind == 2'(`FGIC_IDX_MASK))
                begin
                    reg_rdata <= mask_arr[rd_dec.grp];
                end
                else
                begin
                    reg_rdata <= sense_arr[rd_dec.grp];
                end
            end
        end
    end

endmodule

//--- bench/fgic_core_sva.sv
`timescale 1ns/1ps

module fgic_core_sva
#(
    parameter int unsigned WAIT_CYCLES = 20
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic powerup_check_select,
    input wire logic power_good_pin_mode_sel,
    input wire logic reset_point_reached,
    input wire logic power_down_req,
    input wire logic [10:0] regulator_enabled,
    input wire logic [10:0] regulation_ok,
    input wire logic [10:0] blanking_done,
    input wire logic early_warning,
    input wire logic host_reset_out_n,
    input wire logic sequence_hold,
    input wire logic sequence_abort,
    input wire logic [10:0] voltage_monitor_en,
    input wire logic power_good_pin,
    input wire logic interrupt_out_n_o,
    input wire logic interrupt_out_n_oe_n
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    logic all_ok;
    int unsigned wait_cnt_reg;
    assign all_ok = &(regulation_ok | ~regulator_enabled);
    // Cycles spent waiting for regulation
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            wait_cnt_reg <= 0;
        else if (sequence_hold && !sequence_abort)
            wait_cnt_reg <= wait_cnt_reg + 1;
        else
            wait_cnt_reg <= 0;
    end
    sequence s_point;
        !host_reset_out_n && !sequence_hold && reset_point_reached;
    endsequence
    sequence s_kept;
        (sequence_abort || host_reset_out_n) && !power_down_req;
    endsequence
    a_check_off_go: assert property (s_point ##0 !powerup_check_select
        |=> host_reset_out_n)
        else $error("release without check missed");
    a_check_ok_go: assert property (s_point ##0 powerup_check_select && all_ok
        |=> host_reset_out_n)
        else $error("release with all ok missed");
    a_check_bad_hold: assert property (s_point ##0 powerup_check_select && !all_ok
        |=> sequence_hold && !host_reset_out_n)
        else $error("hold on bad regulator missed");
    a_hold_keeps_reset: assert property (sequence_hold |-> !host_reset_out_n)
        else $error("reset released while held");
    a_wait_bound: assert property (wait_cnt_reg <= WAIT_CYCLES + 1)
        else $error("wait ran past its limit");
    a_state_sticky: assert property (s_kept
        |=> $stable(host_reset_out_n) && $stable(sequence_abort))
        else $error("supervision state left early");
    a_monitor_gate: assert property (voltage_monitor_en ==
        (host_reset_out_n ? blanking_done : 11'h000))
        else $error("monitor enable wrong");
    a_power_good_pin_wait: assert property (sequence_hold && !sequence_abort && power_good_pin_mode_sel
        |-> !power_good_pin)
        else $error("power good not low in wait");
    a_early_irq: assert property (early_warning
        |-> !interrupt_out_n_oe_n && !interrupt_out_n_o)
        else $error("early warning not on interrupt");
endmodule

bind fgic_core fgic_core_sva #(.WAIT_CYCLES(WAIT_CYCLES)) fgic_core_sva_i (.sys_clk, .rst_b,
    .powerup_check_select, .power_good_pin_mode_sel, .reset_point_reached, .power_down_req,
    .regulator_enabled, .regulation_ok, .blanking_done, .early_warning, .host_reset_out_n,
    .sequence_hold, .sequence_abort, .voltage_monitor_en, .power_good_pin,
    .interrupt_out_n_o, .interrupt_out_n_oe_n);

//--- bench/fgic_host_model.sv
`timescale 1ns/1ps

module fgic_host_model
(
    input wire logic pin_o,
    input wire logic pin_oe_n,
    output wire logic irq_n,
    output int irq_seen
);
    // Open-drain line, pulled up when released
    assign irq_n = pin_oe_n ? 1'b1 : pin_o;
    initial irq_seen = 0;
    always @(negedge irq_n)
        irq_seen++;
endmodule

//--- bench/fgic_core_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
    $display("wrong value at %0t: %h %h", $time, (a), (b)); end end

module fgic_core_bench
    import fgic_pkg::*;
;
    logic sys_clk, rst_b, reg_rvalid, powerup_check_select, power_good_pin_mode_sel;
    logic reset_point_reached, power_down_req, early_warning, host_reset_out_n;
    logic sequence_hold, sequence_abort, power_good_pin, interrupt_out_n_o;
    logic interrupt_out_n_oe_n, irq_n;
    logic [7:0] reg_rdata, status1_event, thermal_event, thermal_live, button_event;
    logic [10:0] regulator_enabled, regulation_ok, blanking_done;
    logic [10:0] regulator_off_req, voltage_monitor_en;
    logic [6:0] buck_mode_event;
    logic [2:0] status1_live;
    logic [1:0] button_live;
    fgic_reg_req_t reg_req;
    fgic_fault_t fault, fault_bypass, protection_start;
    int fails, samples_checked, irq_seen, n;

    fgic_core #(.WAIT_CYCLES(20)) fgic_core_i (.sys_clk, .rst_b, .reg_req, .reg_rdata,
        .reg_rvalid, .powerup_check_select, .power_good_pin_mode_sel, .reset_point_reached,
        .power_down_req, .regulator_enabled, .regulation_ok, .blanking_done, .fault,
        .fault_bypass, .status1_event, .status1_live, .thermal_event, .thermal_live,
        .buck_mode_event, .button_event, .button_live, .early_warning, .host_reset_out_n,
        .sequence_hold, .sequence_abort, .regulator_off_req, .voltage_monitor_en,
        .protection_start, .power_good_pin, .interrupt_out_n_o, .interrupt_out_n_oe_n);
    fgic_host_model fgic_host_model_i (.pin_o(interrupt_out_n_o),
        .pin_oe_n(interrupt_out_n_oe_n), .irq_n, .irq_seen);

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task tick;
        @(posedge sys_clk);
        #1;
    endtask
    task wr(input logic [4:0] i, input logic [7:0] v);
        reg_req.idx = i;
        reg_req.wdata = v;
        reg_req.wr = 1'b1;
        tick;
        reg_req.wr = 1'b0;
        tick;
    endtask
    task rd(input logic [4:0] i, input logic [7:0] x);
        reg_req.idx = i;
        reg_req.rd = 1'b1;
        tick;
        reg_req.rd = 1'b0;
        `CHK(reg_rvalid, 1'b1)
        `CHK(reg_rdata, x)
        tick;
    endtask
    task point(input logic c);
        powerup_check_select = c;
        reset_point_reached = 1'b1;
        tick;
        reset_point_reached = 1'b0;
    endtask
    task down;
        power_down_req = 1'b1;
        tick;
        power_down_req = 1'b0;
        tick;
        `CHK(host_reset_out_n, 1'b0)
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task t_regs;
        rd(5'h01, 8'hff);
        rd(5'h00, 8'h00);
        rd(5'h07, 8'h7f);
        rd(5'h0d, 8'h0f);
        rd(5'h1f, 8'h00);
    endtask
    task t_latch;
        wr(5'h01, 8'hfe);
        status1_event = 8'h81;
        tick;
        status1_event = 8'h00;
        rd(5'h00, 8'h81);
        `CHK(irq_n, 1'b0)
        rd(5'h1e, 8'h01);
        wr(5'h00, 8'h00);
        rd(5'h00, 8'h81);
        wr(5'h1e, 8'hff);
        rd(5'h1e, 8'h01);
        wr(5'h00, 8'h01);
        rd(5'h00, 8'h80);
        `CHK(irq_n, 1'b1)
        rd(5'h1e, 8'h00);
        status1_live = 3'h5;
        button_live = 2'b10;
        rd(5'h02, 8'h05);
        rd(5'h1d, 8'h80);
    endtask
    task t_groups;
        wr(5'h04, 8'h00);
        wr(5'h07, 8'h00);
        wr(5'h1c, 8'h00);
        thermal_event = 8'h01;
        buck_mode_event = 7'h40;
        button_event = 8'h80;
        tick;
        {thermal_event, buck_mode_event, button_event} = '0;
        rd(5'h1e, 8'h46);
        wr(5'h03, 8'h01);
        wr(5'h06, 8'h40);
        rd(5'h1e, 8'h40);
        `CHK(irq_n, 1'b0)
        wr(5'h1b, 8'h80);
        `CHK(irq_n, 1'b1)
    endtask
    task t_release;
        regulator_enabled = 11'h083;
        blanking_done = 11'h001;
        point(1'b0);
        `CHK(host_reset_out_n, 1'b1)
        `CHK(voltage_monitor_en, 11'h001)
        wr(5'h0a, 8'hfe);
        wr(5'h0d, 8'hfe);
        fault_bypass.current_limit = 11'h080;
        fault.current_limit = 11'h081;
        repeat (3) tick;
        `CHK(protection_start.current_limit, 11'h001)
        fault.current_limit = 11'h000;
        rd(5'h09, 8'h01);
        rd(5'h0c, 8'h01);
        rd(5'h1e, 8'h08);
        `CHK(sequence_hold, 1'b0)
        wr(5'h09, 8'h01);
        wr(5'h0c, 8'h01);
        rd(5'h1e, 8'h00);
        down;
    endtask
    task t_wait;
        power_good_pin_mode_sel = 1'b1;
        regulator_enabled = 11'h003;
        regulation_ok = 11'h001;
        point(1'b1);
        `CHK(sequence_hold, 1'b1)
        `CHK(host_reset_out_n, 1'b0)
        `CHK(power_good_pin, 1'b0)
        repeat (5) tick;
        regulation_ok = 11'h003;
        repeat (2) tick;
        `CHK(host_reset_out_n, 1'b1)
        down;
        regulation_ok = 11'h000;
        point(1'b1);
        n = 0;
        while (sequence_abort !== 1'b1 && n < 60)
        begin
            tick;
            n++;
        end
        `CHK(n, 20)
        `CHK(regulator_off_req, 11'h003)
        down;
    endtask
    task t_ewarn;
        early_warning = 1'b1;
        tick;
        `CHK(irq_n, 1'b0)
        rd(5'h1e, 8'h80);
        early_warning = 1'b0;
        `CHK(irq_seen > 0, 1'b1)
    endtask

    initial
    begin
        {rst_b, powerup_check_select, power_good_pin_mode_sel, reset_point_reached} = '0;
        {power_down_req, early_warning, status1_event, thermal_event} = '0;
        {thermal_live, button_event, buck_mode_event, status1_live, button_live} = '0;
        {regulator_enabled, regulation_ok, blanking_done} = '0;
        {reg_req, fault, fault_bypass} = '0;
        {fails, samples_checked} = '0;
        repeat (5) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        t_regs;
        t_latch;
        t_groups;
        t_release;
        t_wait;
        t_ewarn;
        complete_run;
    end
    initial
    begin
        #20000;
        fails++;
        complete_run;
    end
endmodule
